// ===== rtl/lsb_unit.sv
// Logic, shift and bit unit: holds eight 32-bit general registers and carry/zero flags
// Assumes decode issues one command per cycle; memory byte comes with the command
`timescale 1ns/10ps
`include "lsb_regs.svh"
module lsb_unit
   import lsb_pkg::*;
#(
   parameter int NREGS = `LSB_NREGS
) (
   // Clock and reset
   input  wire logic     clk_sys,
   input  wire logic     rstn,
   // Command from decode
   input  wire logic     cmd_valid,
   input  wire lsb_cmd_t cmd,
   input  wire logic [7:0] mem_rdata,
   // Results
   output lsb_res_t      res_r,
   output logic          done_r,
   output logic          bad_cmd_r,
   output logic [7:0]    condition_flags_r,
   output logic [31:0]   reg_view_r [NREGS]
);
   logic [31:0] gpr_r [NREGS];
   logic        carry_r, zero_r;

   // Read a sized view of a register
   function automatic logic [31:0] rd_view(input logic [31:0] v, input lsb_size_t s,
                                           input logic hi, input logic e);
      rd_view = 32'h0000_0000;
      unique case (s)
         SZ_BYTE: rd_view = {24'h00_0000, hi ? v[15:8] : v[7:0]};
         SZ_WORD: rd_view = {16'h0000, e ? v[31:16] : v[15:0]};
         default: rd_view = v;
      endcase
   endfunction

   // Merge a sized result into a register, untouched parts kept
   function automatic logic [31:0] wr_view(input logic [31:0] v, input logic [31:0] d,
                                           input lsb_size_t s, input logic hi, input logic e);
      wr_view = v;
      unique case (s)
         SZ_BYTE: if (hi) wr_view[15:8] = d[7:0]; else wr_view[7:0] = d[7:0];
         SZ_WORD: if (e) wr_view[31:16] = d[15:0]; else wr_view[15:0] = d[15:0];
         default: wr_view = d;
      endcase
   endfunction

   function automatic logic [4:0] msb_of(input lsb_size_t s);
      unique case (s)
         SZ_BYTE: msb_of = `LSB_BYTE_MSB;
         SZ_WORD: msb_of = `LSB_WORD_MSB;
         default: msb_of = `LSB_LONG_MSB;
      endcase
   endfunction

   logic [31:0] dst_v, src_v, opb, alu_out, bit_byte, bit_out;
   logic [4:0]  msb;
   logic        top_bit, low_bit, new_carry, new_zero, wr_reg, wr_mem, bad;
   logic [2:0]  bitno;
   logic        sel_bit, sel_eff;

   assign dst_v = rd_view(gpr_r[cmd.dst], cmd.size, cmd.dst_hi, cmd.dst_e);
   assign src_v = rd_view(gpr_r[cmd.src], cmd.size, cmd.src_hi, cmd.src_e);
   assign opb   = cmd.use_imm ? cmd.imm : src_v;
   assign msb   = msb_of(cmd.size);
   assign top_bit = dst_v[msb];
   assign low_bit = dst_v[0];
   // Bit number source; register form reads the low three bits only
   assign bitno = cmd.use_imm ? cmd.imm[`LSB_BITNO_W-1:0] : src_v[`LSB_BITNO_W-1:0];
   // Bit operand is a byte register or a memory byte; byte view whatever the size field says
   assign bit_byte = cmd.mem ? {24'h00_0000, mem_rdata}
                             : rd_view(gpr_r[cmd.dst], SZ_BYTE, cmd.dst_hi, cmd.dst_e);
   assign sel_bit  = bit_byte[bitno];
   assign sel_eff  = cmd.inv ? ~sel_bit : sel_bit;

   // Datapath: result and next carry/zero; zero changes only on the bit test, other ops hold it
   always_comb begin
      alu_out   = dst_v;
      bit_out   = bit_byte;
      new_carry = carry_r;
      new_zero  = zero_r;
      wr_reg    = 1'b0;
      wr_mem    = 1'b0;
      bad       = 1'b0;
      unique case (cmd.op)
         OP_AND: begin alu_out = dst_v & opb; wr_reg = 1'b1; end
         OP_OR:  begin alu_out = dst_v | opb; wr_reg = 1'b1; end
         OP_XOR: begin alu_out = dst_v ^ opb; wr_reg = 1'b1; end
         OP_NOT: begin alu_out = ~dst_v; wr_reg = 1'b1; end
         OP_ARITH_SHIFT_LEFT, OP_LOGIC_SHIFT_LEFT: begin
            alu_out = dst_v << 1;
            new_carry = top_bit;
            wr_reg = 1'b1;
         end
         OP_ARITH_SHIFT_RIGHT: begin
            alu_out = dst_v >> 1;
            alu_out[msb] = top_bit;
            new_carry = low_bit;
            wr_reg = 1'b1;
         end
         OP_LOGIC_SHIFT_RIGHT: begin
            alu_out = dst_v >> 1;
            new_carry = low_bit;
            wr_reg = 1'b1;
         end
         OP_ROTATE_LEFT: begin
            alu_out = dst_v << 1;
            alu_out[0] = top_bit;
            new_carry = top_bit;
            wr_reg = 1'b1;
         end
         OP_ROTATE_RIGHT: begin
            alu_out = dst_v >> 1;
            alu_out[msb] = low_bit;
            new_carry = low_bit;
            wr_reg = 1'b1;
         end
         OP_ROTATE_CARRY_LEFT: begin
            alu_out = dst_v << 1;
            alu_out[0] = carry_r;
            new_carry = top_bit;
            wr_reg = 1'b1;
         end
         OP_ROTATE_CARRY_RIGHT: begin
            alu_out = dst_v >> 1;
            alu_out[msb] = carry_r;
            new_carry = low_bit;
            wr_reg = 1'b1;
         end
         OP_BIT_FORCE_ONE: begin
            bit_out[bitno] = 1'b1;
            wr_reg = ~cmd.mem;
            wr_mem = cmd.mem;
         end
         OP_BIT_FORCE_ZERO: begin
            bit_out[bitno] = 1'b0;
            wr_reg = ~cmd.mem;
            wr_mem = cmd.mem;
         end
         OP_BIT_INVERT: begin
            bit_out[bitno] = ~sel_bit;
            wr_reg = ~cmd.mem;
            wr_mem = cmd.mem;
         end
         OP_BIT_TEST_ZERO_FLAG: new_zero = ~sel_bit;
         OP_CARRY_AND_BIT: new_carry = carry_r & sel_eff;
         OP_CARRY_OR_BIT:  new_carry = carry_r | sel_eff;
         OP_CARRY_XOR_BIT: new_carry = carry_r ^ sel_eff;
         OP_BIT_TO_CARRY:  new_carry = sel_eff;
         OP_CARRY_TO_BIT: begin
            bit_out[bitno] = cmd.inv ? ~carry_r : carry_r;
            wr_reg = ~cmd.mem;
            wr_mem = cmd.mem;
         end
         default: ;
      endcase
      // Inverted variants with a register bit number are refused whole
      if (cmd.inv && !cmd.use_imm) begin
         bad = 1'b1;
         wr_reg = 1'b0;
         wr_mem = 1'b0;
         new_carry = carry_r;
         new_zero = zero_r;
      end
      if (!cmd_valid) begin
         wr_reg = 1'b0;
         wr_mem = 1'b0;
         bad = 1'b0;
         new_carry = carry_r;
         new_zero = zero_r;
      end
   end

   logic is_bit_op;
   assign is_bit_op = cmd.op inside {OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO, OP_BIT_INVERT,
                                     OP_CARRY_TO_BIT};

   // Register file write-back; bit ops always act on a byte view
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NREGS; i++) gpr_r[i] <= 32'h0000_0000;
      end else if (wr_reg) begin
         gpr_r[cmd.dst] <= wr_view(gpr_r[cmd.dst], is_bit_op ? bit_out : alu_out,
                                   is_bit_op ? SZ_BYTE : cmd.size, cmd.dst_hi, cmd.dst_e);
      end
   end

   // Flags; only carry and zero are touched by this unit
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         carry_r <= 1'b0;
         zero_r  <= 1'b0;
      end else begin
         carry_r <= new_carry;
         zero_r  <= new_zero;
      end
   end

   // Registered outputs
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         res_r     <= '0;
         done_r    <= 1'b0;
         bad_cmd_r <= 1'b0;
      end else begin
         res_r.wr_reg <= wr_reg;
         res_r.wr_mem <= wr_mem;
         res_r.data   <= wr_mem ? {24'h00_0000, bit_out[7:0]} : (is_bit_op ? bit_out : alu_out);
         done_r       <= cmd_valid & ~bad;
         bad_cmd_r    <= bad;
      end
   end

   // Flag byte view: carry in bit 0, zero in bit 2; others read zero
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) condition_flags_r <= 8'h00;
      else condition_flags_r <= {5'h00, new_zero, 1'b0, new_carry};
   end

   // Mirror of the register file, one cycle behind updates
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NREGS; i++) reg_view_r[i] <= 32'h0000_0000;
      end else begin
         for (int i = 0; i < NREGS; i++) reg_view_r[i] <= gpr_r[i];
      end
   end

   // Checks
   chk_test_keeps_reg: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmd_valid && cmd.op == OP_BIT_TEST_ZERO_FLAG |-> !wr_reg && !wr_mem)
      else $error("bit test wrote its operand");
   chk_test_zero_val: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmd_valid && cmd.op == OP_BIT_TEST_ZERO_FLAG && !cmd.inv |=> zero_r == !$past(sel_bit))
      else $error("zero flag not inverted bit");
   chk_inv_reg_refused: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmd_valid && cmd.inv && !cmd.use_imm |=> bad_cmd_r && $stable(carry_r))
      else $error("inverted variant with register bit number accepted");
   chk_bit_to_carry: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmd_valid && cmd.op == OP_BIT_TO_CARRY && !bad |=> carry_r == $past(sel_eff))
      else $error("bit load wrong");
   chk_shl_carry_out: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmd_valid && cmd.op == OP_LOGIC_SHIFT_LEFT && !bad |=> carry_r == $past(top_bit))
      else $error("shift left carry wrong");
   chk_shr_zero_fill: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmd_valid && cmd.op == OP_LOGIC_SHIFT_RIGHT && !bad |-> alu_out[msb] == 1'b0)
      else $error("logical right shift not zero filled");
   chk_sar_sign_keep: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmd_valid && cmd.op == OP_ARITH_SHIFT_RIGHT |-> alu_out[msb] == top_bit)
      else $error("sign not kept");
   chk_bit_force_one_result: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmd_valid && cmd.op == OP_BIT_FORCE_ONE && !bad |=> res_r.data[$past(bitno)] == 1'b1)
      else $error("bit not set");
   chk_and_result: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmd_valid && cmd.op == OP_AND && !bad |=>
         res_r.data == ($past(dst_v) & $past(opb)) && res_r.wr_reg)
      else $error("and result wrong");
   chk_rotc_in: assert property (@(posedge clk_sys) disable iff (!rstn)
      cmd_valid && cmd.op == OP_ROTATE_CARRY_LEFT && !bad |-> alu_out[0] == carry_r)
      else $error("carry not rotated in");
endmodule

// ===== rtl/lsb_regs.svh
// Constants for the logic, shift and bit unit
// Assumes inclusion by bare name from rtl/
`ifndef LSB_REGS_SVH
`define LSB_REGS_SVH
`define LSB_BYTE_MSB   5'h07
`define LSB_WORD_MSB   5'h0F
`define LSB_LONG_MSB   5'h1F
`define LSB_BITNO_W    3
`define LSB_REG_IDX_W  3
`define LSB_NREGS      8
`endif

// ===== rtl/lsb_pkg.sv
// Types for the logic, shift and bit unit
// Assumes lsb_regs.svh is in the include path
package lsb_pkg;
   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} lsb_size_t;
   typedef enum logic [4:0] {
      OP_NONE, OP_AND, OP_OR, OP_XOR, OP_NOT,
      OP_ARITH_SHIFT_LEFT, OP_ARITH_SHIFT_RIGHT, OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT,
      OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_ROTATE_CARRY_LEFT, OP_ROTATE_CARRY_RIGHT,
      OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO, OP_BIT_INVERT, OP_BIT_TEST_ZERO_FLAG,
      OP_CARRY_AND_BIT, OP_CARRY_OR_BIT, OP_CARRY_XOR_BIT, OP_BIT_TO_CARRY,
      OP_CARRY_TO_BIT
   } lsb_op_t;
   // One issued operation from decode and operand fetch
   typedef struct packed {
      lsb_op_t   op;
      lsb_size_t size;
      logic      use_imm;   // Second operand or bit number from immediate
      logic      inv;       // Inverted-bit variant
      logic      mem;       // Bit operand is a memory byte
      logic [2:0] dst;      // Destination 32-bit register index
      logic      dst_hi;    // Byte view: upper half of low word
      logic      dst_e;     // Word view: upper 16 bits (extended register)
      logic [2:0] src;      // Source register index
      logic      src_hi;
      logic      src_e;
      logic [31:0] imm;
   } lsb_cmd_t;
   // Result toward register file or memory
   typedef struct packed {
      logic        wr_reg;
      logic        wr_mem;
      logic [31:0] data;
   } lsb_res_t;
endpackage

// ===== sim/test_logic_shift_bit_unit.sv
// Directed testbench for lsb_unit: logic, shift, rotate and bit commands
// Assumes lsb_pkg and lsb_unit compiled first; one command issued at a time
`timescale 1ns/10ps
module test_logic_shift_bit_unit;
   import lsb_pkg::*;
   logic        clk_sys;
   logic        rstn;
   logic        cmd_valid;
   lsb_cmd_t    cmd;
   logic [7:0]  mem_rdata;
   lsb_res_t    res_r;
   logic        done_r;
   logic        bad_cmd_r;
   logic [7:0]  condition_flags_r;
   logic [31:0] reg_view_r [8];
   logic        hi_sel;
   logic        mem_sel;
   logic [2:0]  src_sel;
   int          failures;
   int          n_checks;

   lsb_unit lsb_unit_i (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
      .mem_rdata(mem_rdata), .res_r(res_r), .done_r(done_r), .bad_cmd_r(bad_cmd_r),
      .condition_flags_r(condition_flags_r), .reg_view_r(reg_view_r));

   // Compare and count
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("Checks %0d, failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // One idle cycle, then one command for one cycle; returns just after the answer edge
   // The idle cycle keeps valid from being lowered and raised in one time step
   task automatic issue(input lsb_op_t op, input lsb_size_t sz, input logic ui,
                        input logic iv, input logic [2:0] d, input logic [31:0] imm);
      @(posedge clk_sys);
      #1;
      cmd_valid = 1'b1;
      cmd = '{op, sz, ui, iv, mem_sel, d, hi_sel, 1'b0, src_sel, 1'b0, 1'b0, imm};
      @(posedge clk_sys);
      #1;
      cmd_valid = 1'b0;
   endtask

   // Issue, then judge data under mask m and carry c (2 skips carry)
   task automatic step(input lsb_op_t op, input lsb_size_t sz, input logic ui,
                       input logic iv, input logic [2:0] d, input logic [31:0] imm,
                       input logic [31:0] m, input logic [31:0] exp, input logic [1:0] c);
      issue(op, sz, ui, iv, d, imm);
      chk("done", {31'h0, done_r}, 32'h1);
      if (m != 32'h0) chk("data", res_r.data & m, exp);
      if (c != 2'h2) chk("carry", {31'h0, condition_flags_r[0]}, {30'h0, c});
   endtask

   task automatic t_reset();
      chk("flags", {24'h0, condition_flags_r}, 32'h0);
      chk("reg7", reg_view_r[7], 32'h0);
   endtask

   task automatic t_logic();
      step(OP_OR, SZ_LONG, 1'b1, 1'b0, 3'h0, 32'hA5A50F0F, 32'hFFFFFFFF, 32'hA5A50F0F, 2'h2);
      step(OP_AND, SZ_LONG, 1'b1, 1'b0, 3'h0, 32'hFFFF00F0, 32'hFFFFFFFF, 32'hA5A50000, 2'h2);
      step(OP_XOR, SZ_WORD, 1'b1, 1'b0, 3'h0, 32'h000000FF, 32'hFFFF, 32'h00FF, 2'h2);
      hi_sel = 1'b1;
      step(OP_NOT, SZ_BYTE, 1'b0, 1'b0, 3'h0, 32'h0, 32'hFF, 32'hFF, 2'h2);
      hi_sel = 1'b0;
      src_sel = 3'h0;
      step(OP_OR, SZ_LONG, 1'b0, 1'b0, 3'h1, 32'h0, 32'hFFFFFFFF, 32'hA5A5FFFF, 2'h2);
      src_sel = 3'h5;
      @(posedge clk_sys);
      #1;
      chk("reg0", reg_view_r[0], 32'hA5A5FFFF);
      chk("reg1", reg_view_r[1], 32'hA5A5FFFF);
   endtask

   // Byte chain on R2 from 0x81; carry feeds the through-carry rotates
   task automatic t_shift();
      lsb_op_t    ops [8] = '{OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_ARITH_SHIFT_RIGHT,
                              OP_LOGIC_SHIFT_LEFT, OP_ROTATE_CARRY_RIGHT,
                              OP_ROTATE_CARRY_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ARITH_SHIFT_LEFT};
      logic [7:0] ev [8] = '{8'h03, 8'h81, 8'hC0, 8'h80, 8'hC0, 8'h80, 8'h40, 8'h80};
      logic [1:0] ec [8] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0};
      step(OP_OR, SZ_BYTE, 1'b1, 1'b0, 3'h2, 32'h81, 32'hFF, 32'h81, 2'h2);
      for (int i = 0; i < 8; i++) begin
         step(ops[i], SZ_BYTE, 1'b0, 1'b0, 3'h2, 32'h0, 32'hFF, {24'h0, ev[i]}, ec[i]);
      end
      step(OP_OR, SZ_LONG, 1'b1, 1'b0, 3'h3, 32'h80000001, 32'h0, 32'h0, 2'h2);
      step(OP_ARITH_SHIFT_RIGHT, SZ_LONG, 1'b0, 1'b0, 3'h3, 32'h0, 32'hFFFFFFFF, 32'hC0000000, 2'h1);
      step(OP_OR, SZ_WORD, 1'b1, 1'b0, 3'h6, 32'h8001, 32'h0, 32'h0, 2'h2);
      step(OP_LOGIC_SHIFT_LEFT, SZ_WORD, 1'b0, 1'b0, 3'h6, 32'h0, 32'hFFFF, 32'h0002, 2'h1);
   endtask

   // Set, clear, invert, test on R4; bit number from immediate and from R5
   task automatic t_bits();
      step(OP_OR, SZ_BYTE, 1'b1, 1'b0, 3'h5, 32'h0B, 32'hFF, 32'h0B, 2'h2);
      step(OP_BIT_FORCE_ONE, SZ_BYTE, 1'b1, 1'b0, 3'h4, 32'h5, 32'hFF, 32'h20, 2'h2);
      step(OP_BIT_FORCE_ONE, SZ_BYTE, 1'b0, 1'b0, 3'h4, 32'h0, 32'hFF, 32'h28, 2'h2);
      step(OP_BIT_FORCE_ZERO, SZ_BYTE, 1'b1, 1'b0, 3'h4, 32'h5, 32'hFF, 32'h08, 2'h2);
      step(OP_BIT_INVERT, SZ_BYTE, 1'b1, 1'b0, 3'h4, 32'h0, 32'hFF, 32'h09, 2'h2);
      step(OP_BIT_TEST_ZERO_FLAG, SZ_BYTE, 1'b1, 1'b0, 3'h4, 32'h3, 32'h0, 32'h0, 2'h2);
      chk("zero", {31'h0, condition_flags_r[2]}, 32'h0);
      step(OP_BIT_TEST_ZERO_FLAG, SZ_BYTE, 1'b1, 1'b0, 3'h4, 32'h2, 32'h0, 32'h0, 2'h2);
      chk("zero", {31'h0, condition_flags_r[2]}, 32'h1);
      mem_sel = 1'b1;
      mem_rdata = 8'hF0;
      step(OP_BIT_FORCE_ZERO, SZ_BYTE, 1'b1, 1'b0, 3'h4, 32'h7, 32'hFF, 32'h70, 2'h2);
      chk("wr_mem", {31'h0, res_r.wr_mem}, 32'h1);
      mem_sel = 1'b0;
      chk("reg4", reg_view_r[4], 32'h09);
   endtask

   // Carry combine, load and store on R4 = 0x09
   task automatic t_carry();
      step(OP_BIT_TO_CARRY, SZ_BYTE, 1'b1, 1'b0, 3'h4, 32'h0, 32'h0, 32'h0, 2'h1);
      step(OP_CARRY_AND_BIT, SZ_BYTE, 1'b1, 1'b1, 3'h4, 32'h0, 32'h0, 32'h0, 2'h0);
      step(OP_CARRY_OR_BIT, SZ_BYTE, 1'b1, 1'b0, 3'h4, 32'h3, 32'h0, 32'h0, 2'h1);
      step(OP_CARRY_AND_BIT, SZ_BYTE, 1'b1, 1'b0, 3'h4, 32'h3, 32'h0, 32'h0, 2'h1);
      step(OP_CARRY_XOR_BIT, SZ_BYTE, 1'b1, 1'b0, 3'h4, 32'h0, 32'h0, 32'h0, 2'h0);
      step(OP_CARRY_OR_BIT, SZ_BYTE, 1'b1, 1'b1, 3'h4, 32'h1, 32'h0, 32'h0, 2'h1);
      step(OP_CARRY_XOR_BIT, SZ_BYTE, 1'b1, 1'b1, 3'h4, 32'h1, 32'h0, 32'h0, 2'h0);
      step(OP_BIT_TO_CARRY, SZ_BYTE, 1'b1, 1'b1, 3'h4, 32'h1, 32'h0, 32'h0, 2'h1);
      step(OP_CARRY_TO_BIT, SZ_BYTE, 1'b1, 1'b0, 3'h4, 32'h7, 32'hFF, 32'h89, 2'h1);
      step(OP_CARRY_TO_BIT, SZ_BYTE, 1'b1, 1'b1, 3'h4, 32'h0, 32'hFF, 32'h88, 2'h1);
   endtask

   // Inverted variant with register bit number must be refused
   task automatic t_refuse();
      issue(OP_CARRY_TO_BIT, SZ_BYTE, 1'b0, 1'b1, 3'h4, 32'h0);
      chk("bad_cmd", {31'h0, bad_cmd_r}, 32'h1);
      chk("wr_reg", {31'h0, res_r.wr_reg}, 32'h0);
      chk("carry", {31'h0, condition_flags_r[0]}, 32'h1);
      @(posedge clk_sys);
      #1;
      chk("reg4", reg_view_r[4], 32'h88);
   endtask

   // 200 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Main sequence: reset for two cycles, then the scenarios
   initial begin
      rstn = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      mem_rdata = 8'h00;
      hi_sel = 1'b0;
      mem_sel = 1'b0;
      src_sel = 3'h5;
      failures = 0;
      n_checks = 0;
      repeat (2) @(posedge clk_sys);
      #1;
      rstn = 1'b1;
      t_reset();
      t_logic();
      t_shift();
      t_bits();
      t_carry();
      t_refuse();
      finish_test();
   end

   // Watchdog: about 80 cycles expected, allow 800
   initial begin
      #4000;
      failures++;
      $display("[FAIL] watchdog expected finish seen timeout");
      finish_test();
   end
endmodule
